// File: common/asp_pkg.sv
// shared constants of the converter serial port and its host controller
// assumes a 250 MHz system clock on both ends
`default_nettype none
package asp_pkg;
    // command table
    localparam logic [7:0] CMD_READ_DATA = 8'h01;
    localparam logic [7:0] CMD_READ_CTRL = 8'h10;
    localparam logic [7:0] CMD_WRITE_CTRL = 8'h50;
    localparam logic [7:0] CMD_CONT_READ = 8'h03;
    localparam logic [7:0] CMD_STOP_CONT = 8'h0f;
    localparam logic [7:0] CMD_SYNC = 8'hfc;
    localparam logic [7:0] CMD_RESET = 8'hfe;
    // analog control register and output word
    localparam int CTRL_READY_BIT = 7;
    localparam int CTRL_BIT_ORDER_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int WORD_BITS = 24;
    localparam logic [23:0] WORD_RESET = 24'h000000;
    // timing
    localparam int IDLE_READY_PULSES = 3;
    localparam int MCLK_PERIOD_NS = 4;
    localparam int RST_WAVE_NS = 32768;
    localparam int RST_WAVE_CYCLES_DEF = (RST_WAVE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int RST_CS_PULSES = 4;
    localparam int SCLK_HALF_CYCLES = 8;
    // host register word indices
    localparam logic [2:0] HREG_CMD = 3'h0;
    localparam logic [2:0] HREG_CFG = 3'h1;
    localparam logic [2:0] HREG_STATUS = 3'h2;
    localparam logic [2:0] HREG_RXDATA = 3'h3;
    // host command word fields
    localparam int HCMD_ARG_LSB = 8;
    localparam int HCMD_NREAD_LSB = 16;
    localparam int HCMD_HAS_ARG_BIT = 18;
    // host config fields
    localparam int HCFG_CPOL_BIT = 0;
    localparam int HCFG_SYNC_N_BIT = 1;
    localparam int HCFG_THREE_WIRE_BIT = 2;
    localparam int HCFG_SHARED_BIT = 3;
    localparam logic [3:0] HCFG_RESET = 4'h2;
    // host status fields
    localparam int HSTAT_BUSY_BIT = 0;
    localparam int HSTAT_READY_N_BIT = 1;
    localparam int HSTAT_REFUSED_BIT = 2;
endpackage : asp_pkg
`default_nettype wire

// File: common/asp_link_if.sv
// serial link between converter port and host
// data out line is pulled high when nobody drives it
`default_nettype none
interface asp_link_if;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    logic dout_oe;
    logic conversion_ready_n;
    logic filter_sync_n;
    logic clock_polarity_select;
    wire logic dout_line;

    assign dout_line = dout_oe ? dout : 1'b1;

    modport dev (
        input sclk, cs_n, din, filter_sync_n, clock_polarity_select,
        output dout, dout_oe, conversion_ready_n
    );
    modport host (
        output sclk, cs_n, din, filter_sync_n, clock_polarity_select,
        input dout_line, conversion_ready_n
    );
endinterface : asp_link_if
`default_nettype wire

// File: hw/asp_device.sv
// converter end of the serial port: slave shifter, ready flag, sync, resets
// assumes conv_load_i pulses from the filter, link pins asynchronous to mclk_i
// Function
// RL1: slave only, never drives clock
// RL2: host holds select low whole transfer
// RL3: select high resets port state
// RL4: works with select tied low
// RL5: clock idle three ready pulses restarts port
// RL6: polarity low: falling edge, idle low
// RL7: polarity high: rising edge, idle high
// RL8: data out released unless shifting
// RL9: continuous mode watches stop and reset bytes
// RL10: host avoids continuous mode on shared wire
// RL11: ready goes low on new word
// RL12: ready returns high after data read
// RL13: ready high before word update
// RL14: ready readable as control bit 7
// RL15: sync pin low resets digital logic
// RL16: port ignores activity while sync low
// RL17: sync completes next clock after release
// RL18: sync command resets filter, holds modulator
// RL19: sync lands after next serial edge
// RL20: three reset sources restore defaults
// RL21: select waveform resets when polarity, clock high
// RL22: msb byte first, bit order selectable
// RL23: inputs synchronised, glitches filtered; din and polarity select are only synchronised, not filtered
// RL24: commands decoded as whole bytes
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`default_nettype none
module asp_device #(
    parameter int RST_WAVE_CYCLES = asp_pkg::RST_WAVE_CYCLES_DEF,
    parameter int CS_RST_PULSES = asp_pkg::RST_CS_PULSES
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    asp_link_if.dev link,
    input wire logic [asp_pkg::WORD_BITS-1:0] conv_word_i,
    input wire logic conv_load_i,
    output logic filter_reset_o,
    output logic modulator_hold_o,
    output logic sync_done_o,
    output logic digital_reset_o,
    output logic soft_reset_o,
    output logic [7:0] ctrl_o
);
    import asp_pkg::*;

    if (RST_WAVE_CYCLES < 16 || RST_WAVE_CYCLES > 65535 || CS_RST_PULSES < 2
        || CS_RST_PULSES > 15) begin : g_bad_param
        $error("asp_device: reset waveform parameters out of range");
    end

    typedef enum logic [3:0] {
        ST_CMD = 4'b0001,
        ST_ARG = 4'b0010,
        ST_TX = 4'b0100,
        ST_CONT = 4'b1000
    } asp_dev_st_e;

    function automatic logic [23:0] asp_order(input logic [23:0] w, input logic lsb_first);
        logic [23:0] r;
        r = w;
        if (lsb_first) begin
            for (int b = 0; b < 3; b++) begin
                for (int i = 0; i < 8; i++) begin
                    r[b*8+i] = w[b*8+7-i];
                end
            end
        end
        return r;
    endfunction : asp_order

    // bit 0 clock, bit 1 select, bit 2 sync pin
    logic [2:0] s0_reg, s1_reg, s2_reg, flt_reg;
    logic [1:0] din_sy_reg, cpol_sy_reg;
    asp_dev_st_e st_reg;
    logic [7:0] rx_reg, ctrl_reg;
    logic [2:0] rx_cnt_reg;
    logic [23:0] tx_reg, stage_reg, word_reg;
    logic [4:0] tx_cnt_reg;
    logic data_rd_reg, oe_reg, dout_reg, pend_reg, ready_n_reg, stale_reg;
    logic [1:0] idle_cnt_reg;
    logic hold_reg, filt_rst_reg, sync_done_reg, soft_rst_reg;
    logic [15:0] wave_cnt_reg;
    logic [3:0] cs_cnt_reg;

    wire logic [2:0] stable = ~(s1_reg ^ s2_reg);
    wire logic [2:0] chg = stable & (s2_reg ^ flt_reg);
    wire logic din_s = din_sy_reg[1];
    wire logic cpol_s = cpol_sy_reg[1];
    wire logic sclk_edge = chg[0];
    wire logic act_edge = sclk_edge & (s2_reg[0] == cpol_s); // see RL6 see RL7
    wire logic lead_edge = sclk_edge & (s2_reg[0] != cpol_s);
    wire logic sync_low = ~flt_reg[2];
    wire logic port_clear = flt_reg[1] | sync_low; // see RL3 see RL16
    wire logic restart = sclk_edge & stale_reg; // see RL5
    wire logic go = ~port_clear & ~restart & ~soft_rst_reg;
    wire logic [7:0] rx_next = {rx_reg[6:0], din_s}; // see RL22
    wire logic byte_done = go & act_edge & (rx_cnt_reg == 3'd7) & (st_reg != ST_TX);
    wire logic cmd_done = byte_done & (st_reg == ST_CMD);
    wire logic sync_cmd = cmd_done & (rx_next == CMD_SYNC); // see RL24
    wire logic reset_cmd = byte_done & (st_reg != ST_ARG) & (rx_next == CMD_RESET); // see RL9
    wire logic last_bit = go & act_edge & (tx_cnt_reg == 5'd1);
    wire logic read_done = last_bit & data_rd_reg; // see RL12
    wire logic lsb_first = ctrl_reg[CTRL_BIT_ORDER_BIT];
    wire logic [7:0] ctrl_view = {ready_n_reg, ctrl_reg[6:0]}; // see RL14
    wire logic idle_lvl = flt_reg[0] == cpol_s;
    wire logic wave_hit = ~idle_lvl & (wave_cnt_reg == 16'(RST_WAVE_CYCLES - 1));
    wire logic cs_fall = chg[1] & ~s2_reg[1];
    wire logic cs_arm = cpol_s & flt_reg[0] & ~sclk_edge;
    wire logic cs_hit = cs_arm & cs_fall & (cs_cnt_reg == 4'(CS_RST_PULSES - 1));

    assign link.dout = dout_reg;
    assign link.dout_oe = oe_reg; // see RL8 see RL1
    assign link.conversion_ready_n = ready_n_reg;
    assign filter_reset_o = filt_rst_reg;
    assign modulator_hold_o = hold_reg;
    assign sync_done_o = sync_done_reg;
    assign digital_reset_o = sync_low; // see RL15
    assign soft_reset_o = soft_rst_reg;
    assign ctrl_o = ctrl_view;

    // two flops; clock, select and sync pin levels are taken only when two samples agree
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s0_reg <= 3'b110;
            s1_reg <= 3'b110;
            s2_reg <= 3'b110;
            flt_reg <= 3'b110;
            din_sy_reg <= 2'b00;
            cpol_sy_reg <= 2'b00;
        end else begin
            s0_reg <= {link.filter_sync_n, link.cs_n, link.sclk};
            s1_reg <= s0_reg;
            s2_reg <= s1_reg;
            flt_reg <= (s2_reg & stable) | (flt_reg & ~stable); // see RL23
            din_sy_reg <= {din_sy_reg[0], link.din};
            cpol_sy_reg <= {cpol_sy_reg[0], link.clock_polarity_select};
        end
    end

    // shifter and command decoder
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= ST_CMD;
            rx_reg <= 8'h00;
            rx_cnt_reg <= 3'd0;
            tx_reg <= 24'h000000;
            tx_cnt_reg <= 5'd0;
            data_rd_reg <= 1'b0;
            oe_reg <= 1'b0;
            dout_reg <= 1'b0;
            ctrl_reg <= CTRL_RESET;
        end else if (soft_rst_reg | port_clear) begin
            st_reg <= ST_CMD; // see RL3 see RL4
            rx_cnt_reg <= 3'd0;
            tx_cnt_reg <= 5'd0;
            oe_reg <= 1'b0;
            if (soft_rst_reg) begin
                ctrl_reg <= CTRL_RESET; // see RL20
            end
        end else if (restart) begin
            st_reg <= ST_CMD; // see RL5
            tx_cnt_reg <= 5'd0;
            oe_reg <= 1'b0;
            rx_reg <= {7'h00, din_s};
            rx_cnt_reg <= act_edge ? 3'd1 : 3'd0;
        end else begin
            if (act_edge && st_reg != ST_TX) begin
                rx_reg <= rx_next;
                rx_cnt_reg <= rx_cnt_reg + 3'd1;
            end
            if (lead_edge && tx_cnt_reg != 5'd0) begin
                dout_reg <= tx_reg[23];
                oe_reg <= 1'b1;
            end
            if (act_edge && tx_cnt_reg != 5'd0) begin
                tx_reg <= {tx_reg[22:0], 1'b0};
                tx_cnt_reg <= tx_cnt_reg - 5'd1;
                if (tx_cnt_reg == 5'd1) begin
                    oe_reg <= 1'b0; // see RL8
                end
            end
            case (st_reg)
                ST_CMD: begin
                    if (byte_done) begin
                        case (rx_next) // see RL24
                            CMD_READ_DATA: begin
                                tx_reg <= asp_order(word_reg, lsb_first); // see RL22
                                tx_cnt_reg <= 5'd24;
                                data_rd_reg <= 1'b1;
                                st_reg <= ST_TX;
                            end
                            CMD_READ_CTRL: begin
                                tx_reg <= asp_order({ctrl_view, 16'h0000}, lsb_first);
                                tx_cnt_reg <= 5'd8;
                                data_rd_reg <= 1'b0;
                                st_reg <= ST_TX;
                            end
                            CMD_WRITE_CTRL: st_reg <= ST_ARG;
                            CMD_CONT_READ: st_reg <= ST_CONT;
                            default: st_reg <= ST_CMD;
                        endcase
                    end
                end
                ST_ARG: begin
                    if (byte_done) begin
                        ctrl_reg <= {1'b0, rx_next[6:0]};
                        st_reg <= ST_CMD;
                    end
                end
                ST_TX: begin
                    if (last_bit) begin
                        st_reg <= ST_CMD;
                    end
                end
                ST_CONT: begin
                    if (byte_done && rx_next == CMD_STOP_CONT) begin
                        st_reg <= ST_CMD; // see RL9
                    end
                    if (pend_reg && (tx_cnt_reg == 5'd0 || last_bit)) begin
                        tx_reg <= asp_order(stage_reg, lsb_first);
                        tx_cnt_reg <= 5'd24;
                        data_rd_reg <= 1'b1;
                    end
                end
                default: st_reg <= ST_CMD;
            endcase
        end
    end

    // output word and ready flag; a new word wins over a finished read
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            stage_reg <= WORD_RESET;
            word_reg <= WORD_RESET;
            pend_reg <= 1'b0;
            ready_n_reg <= 1'b1;
        end else if (soft_rst_reg) begin
            word_reg <= WORD_RESET; // see RL20
            pend_reg <= 1'b0;
            ready_n_reg <= 1'b1;
        end else begin
            pend_reg <= conv_load_i;
            if (conv_load_i) begin
                stage_reg <= conv_word_i;
                ready_n_reg <= 1'b1; // see RL13
            end else if (pend_reg) begin
                word_reg <= stage_reg;
                ready_n_reg <= 1'b0; // see RL11
            end else if (read_done) begin
                ready_n_reg <= 1'b1; // see RL12
            end
        end
    end

    // idle watch, sync, reset waveforms
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            idle_cnt_reg <= 2'd0;
            stale_reg <= 1'b0;
            hold_reg <= 1'b0;
            filt_rst_reg <= 1'b0;
            sync_done_reg <= 1'b0;
            soft_rst_reg <= 1'b0;
            wave_cnt_reg <= 16'h0000;
            cs_cnt_reg <= 4'h0;
        end else begin
            if (sclk_edge || port_clear) begin
                idle_cnt_reg <= 2'd0;
            end else if (pend_reg && idle_cnt_reg != 2'(IDLE_READY_PULSES)) begin
                idle_cnt_reg <= idle_cnt_reg + 2'd1;
            end
            stale_reg <= ~sclk_edge & ~port_clear
                & (idle_cnt_reg == 2'(IDLE_READY_PULSES)); // see RL5
            filt_rst_reg <= sync_cmd; // see RL18
            if (sync_cmd) begin
                hold_reg <= 1'b1;
            end else if (sclk_edge || soft_rst_reg) begin
                hold_reg <= 1'b0;
            end
            sync_done_reg <= (chg[2] & s2_reg[2]) | (hold_reg & sclk_edge); // see RL17 see RL19
            soft_rst_reg <= reset_cmd | wave_hit | cs_hit; // see RL20
            if (idle_lvl) begin
                wave_cnt_reg <= 16'h0000;
            end else if (wave_cnt_reg != 16'(RST_WAVE_CYCLES)) begin
                wave_cnt_reg <= wave_cnt_reg + 16'h0001;
            end
            if (!cs_arm || cs_hit) begin
                cs_cnt_reg <= 4'h0;
            end else if (cs_fall) begin
                cs_cnt_reg <= cs_cnt_reg + 4'h1; // see RL21
            end
        end
    end
endmodule : asp_device
`default_nettype wire

// File: hw/asp_host.sv
// host end: avalon-mm slave registers driving a serial bus master
// assumes the converter end answers on the shared link interface
`default_nettype none
module asp_host #(
    parameter int HALF_CYCLES = asp_pkg::SCLK_HALF_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    asp_link_if.host link,
    input wire logic [2:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    import asp_pkg::*;

    if (HALF_CYCLES < 8 || HALF_CYCLES > 255) begin : g_bad_param
        $error("asp_host: half period must be 8 to 255 cycles");
    end

    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_WAIT = 5'b00010,
        H_START = 5'b00100,
        H_SHIFT = 5'b01000,
        H_END = 5'b10000
    } asp_host_st_e;

    asp_host_st_e st_reg;
    logic [3:0] cfg_reg;
    logic [31:0] tx_reg, rd_reg;
    logic [23:0] rx_reg;
    logic [5:0] bits_reg;
    logic [7:0] div_reg;
    logic phase_reg, sclk_reg, cs_reg, din_reg, refused_reg, ack_reg;
    logic [1:0] dout_sy_reg, rdy_sy_reg;

    wire logic req = avs_read_i | avs_write_i;
    wire logic wr_fire = avs_write_i & ack_reg;
    wire logic tick = div_reg == 8'(HALF_CYCLES - 1);
    wire logic cpol = cfg_reg[HCFG_CPOL_BIT];
    wire logic [7:0] cmd = avs_writedata_i[7:0];
    wire logic has_arg = avs_writedata_i[HCMD_HAS_ARG_BIT];
    wire logic [1:0] nread = avs_writedata_i[HCMD_NREAD_LSB +: 2];
    wire logic cmd_wr = wr_fire & (avs_address_i == HREG_CMD) & (st_reg == H_IDLE);
    wire logic refuse = (cmd == CMD_CONT_READ) & cfg_reg[HCFG_SHARED_BIT]; // see RL10
    wire logic [5:0] nbits = 6'd8 + (has_arg ? 6'd8 : 6'd0) + {1'b0, nread, 3'b000};
    wire logic busy = st_reg != H_IDLE;
    wire logic [31:0] status = {29'h0, refused_reg, rdy_sy_reg[1], busy};
    wire logic [31:0] rd_mux = (avs_address_i == HREG_CFG) ? {28'h0, cfg_reg}
        : (avs_address_i == HREG_STATUS) ? status
        : (avs_address_i == HREG_RXDATA) ? {8'h00, rx_reg} : 32'h00000000;

    assign avs_waitrequest_o = req & ~ack_reg;
    assign avs_readdata_o = rd_reg;
    assign link.sclk = sclk_reg;
    assign link.cs_n = cs_reg;
    assign link.din = din_reg;
    assign link.filter_sync_n = cfg_reg[HCFG_SYNC_N_BIT];
    assign link.clock_polarity_select = cpol;

    // one wait cycle, then write takes effect and read data stand
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rd_reg <= 32'h00000000;
            cfg_reg <= HCFG_RESET;
            refused_reg <= 1'b0;
            dout_sy_reg <= 2'b11;
            rdy_sy_reg <= 2'b11;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (avs_read_i && !ack_reg) begin
                rd_reg <= rd_mux;
            end
            if (wr_fire && avs_address_i == HREG_CFG) begin
                cfg_reg <= avs_writedata_i[3:0];
            end
            if (cmd_wr) begin
                refused_reg <= refuse;
            end
            dout_sy_reg <= {dout_sy_reg[0], link.dout_line};
            rdy_sy_reg <= {rdy_sy_reg[0], link.conversion_ready_n};
        end
    end

    // serial master, clock from a divider
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= H_IDLE;
            tx_reg <= 32'h00000000;
            rx_reg <= 24'h000000;
            bits_reg <= 6'd0;
            div_reg <= 8'h00;
            phase_reg <= 1'b0;
            sclk_reg <= 1'b0;
            cs_reg <= 1'b1;
            din_reg <= 1'b0;
        end else begin
            div_reg <= (st_reg == H_IDLE || tick) ? 8'h00 : div_reg + 8'h01;
            case (st_reg)
                H_IDLE: begin
                    sclk_reg <= cpol; // see RL6 see RL7
                    cs_reg <= ~cfg_reg[HCFG_THREE_WIRE_BIT]; // see RL4
                    if (cmd_wr && !refuse) begin
                        tx_reg <= {cmd, has_arg ? avs_writedata_i[15:8] : 8'h00, 16'h0000};
                        bits_reg <= nbits;
                        rx_reg <= 24'h000000;
                        phase_reg <= 1'b0;
                        st_reg <= (cmd == CMD_READ_DATA) ? H_WAIT : H_START;
                    end
                end
                H_WAIT: begin
                    if (!rdy_sy_reg[1]) begin
                        st_reg <= H_START; // see RL13
                    end
                end
                H_START: begin
                    cs_reg <= 1'b0; // see RL2
                    if (tick) begin
                        st_reg <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (tick) begin
                        phase_reg <= ~phase_reg;
                        if (!phase_reg) begin
                            sclk_reg <= ~cpol;
                            din_reg <= tx_reg[31];
                        end else begin
                            sclk_reg <= cpol;
                            rx_reg <= {rx_reg[22:0], dout_sy_reg[1]};
                            tx_reg <= {tx_reg[30:0], 1'b0};
                            bits_reg <= bits_reg - 6'd1;
                            if (bits_reg == 6'd1) begin
                                st_reg <= H_END;
                            end
                        end
                    end
                end
                H_END: begin
                    if (tick) begin
                        st_reg <= H_IDLE;
                    end
                end
                default: st_reg <= H_IDLE;
            endcase
        end
    end
endmodule : asp_host
`default_nettype wire

// File: bench/asp_link_assertions.sv
// assertions on the serial link between converter port and host
// instantiated beside the link interface, sees its signals as plain inputs
`default_nettype none
module asp_link_assertions (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic conversion_ready_n,
    input wire logic filter_sync_n,
    input wire logic clock_polarity_select
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_deselected;
        cs_n [*6];
    endsequence
    sequence s_sync_held;
        !filter_sync_n [*6];
    endsequence
    sequence s_cpol_steady;
        $stable(clock_polarity_select) [*3];
    endsequence
    a_cs_releases: assert property (s_deselected |-> !dout_oe)
        else $error("data out driven while deselected");
    a_sync_silent: assert property (s_sync_held |-> !dout_oe)
        else $error("data out driven while sync held low");
    a_oe_in_frame: assert property ($rose(dout_oe) |-> !cs_n && filter_sync_n)
        else $error("data out enabled outside a frame");
    a_oe_lead_phase: assert property ($rose(dout_oe) |-> sclk != clock_polarity_select)
        else $error("data out enabled in the idle phase");
    a_dout_lead_phase: assert property (dout_oe && $past(dout_oe) && $changed(dout)
        |-> sclk != clock_polarity_select)
        else $error("data out changed near the active edge");
    a_sclk_idle_level: assert property (s_cpol_steady and cs_n [*3]
        |-> sclk == clock_polarity_select)
        else $error("serial clock not idle between frames");
    a_frame_idle_start: assert property ($fell(cs_n) |-> sclk == clock_polarity_select)
        else $error("frame opened with clock off idle");
    a_cs_held_low: assert property (s_cpol_steady ##0 sclk != clock_polarity_select
        |-> !cs_n)
        else $error("select high while clock is active");
endmodule : asp_link_assertions
`default_nettype wire

// File: bench/adc_serial_slave_port_bench.sv
// self-checking bench: host and converter port joined over the link
// assumes one shared 250 MHz clock and one reset for both ends
`default_nettype none
module adc_serial_slave_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import asp_pkg::*;
`define CHK(n, g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] adr = 3'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata;
    logic wreq;
    logic [23:0] cw = 24'h0;
    logic cl = 1'b0;
    logic frst, mhold, sdone, drst, srst;
    logic [7:0] ctrl;
    int err_count = 0;
    int check_count = 0;
    int fr_n = 0;
    int sr_n = 0;
    int sd_n = 0;
    logic [63:0] exp_q[$];
    logic [63:0] e;
    logic [15:0] lf = 16'd18748;
    logic [23:0] w;
    always #2 mclk_i = ~mclk_i;
    asp_link_if link_if();
    asp_device #(.RST_WAVE_CYCLES(64), .CS_RST_PULSES(RST_CS_PULSES)) asp_device_i (
        .mclk_i(mclk_i), .rst_i(rst_i), .link(link_if), .conv_word_i(cw), .conv_load_i(cl),
        .filter_reset_o(frst), .modulator_hold_o(mhold), .sync_done_o(sdone),
        .digital_reset_o(drst), .soft_reset_o(srst), .ctrl_o(ctrl));
    asp_host #(.HALF_CYCLES(SCLK_HALF_CYCLES)) asp_host_i (
        .mclk_i(mclk_i), .rst_i(rst_i), .link(link_if), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq));
    asp_link_assertions asp_link_assertions_i (
        .mclk_i(mclk_i), .rst_i(rst_i), .sclk(link_if.sclk), .cs_n(link_if.cs_n),
        .din(link_if.din), .dout(link_if.dout), .dout_oe(link_if.dout_oe),
        .conversion_ready_n(link_if.conversion_ready_n),
        .filter_sync_n(link_if.filter_sync_n),
        .clock_polarity_select(link_if.clock_polarity_select));
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nx
    // bit order reversed inside each byte, bytes kept in place
    function automatic logic [23:0] rv(input logic [23:0] v);
        for (int i = 0; i < 24; i++) rv[i] = v[(i / 8) * 8 + 7 - i % 8];
    endfunction : rv
    task automatic rd_reg(input logic [2:0] a, input logic [31:0] x, input logic [31:0] m,
            output logic [31:0] d);
        @(posedge mclk_i);
        exp_q.push_back({m, x});
        adr <= a;
        rd <= 1'b1;
        do @(posedge mclk_i); while (wreq !== 1'b0);
        d = rdata;
        rd <= 1'b0;
    endtask : rd_reg
    task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        adr <= a;
        wd <= d;
        wr <= 1'b1;
        do @(posedge mclk_i); while (wreq !== 1'b0);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic chk(input logic [2:0] a, input logic [31:0] x, input logic [31:0] m = '1);
        logic [31:0] d;
        rd_reg(a, x, m, d);
    endtask : chk
    task automatic cmd(input logic [31:0] c);
        logic [31:0] d;
        wr_reg(HREG_CMD, c);
        d = 32'h1;
        while (d[HSTAT_BUSY_BIT] !== 1'b0) rd_reg(HREG_STATUS, 32'h0, 32'h0, d);
    endtask : cmd
    task automatic load;
        lf = nx(lf);
        w[23:8] = lf;
        lf = nx(lf);
        w[7:0] = lf[7:0];
        @(posedge mclk_i);
        cw <= w;
        cl <= 1'b1;
        @(posedge mclk_i);
        cl <= 1'b0;
    endtask : load
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    always @(posedge mclk_i) begin
        if (rd && wreq === 1'b0 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e[63:32] != 0) `CHK("readdata", rdata & e[63:32], e[31:0])
        end
    end
    always @(posedge mclk_i) begin
        if (frst === 1'b1) fr_n++;
        if (sdone === 1'b1) sd_n++;
        if (srst === 1'b1) sr_n++;
    end
    initial begin
        repeat (40000) @(posedge mclk_i);
        err_count++;
        test_done;
    end
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        chk(HREG_STATUS, 32'h2);
        chk(HREG_CFG, {28'h0, HCFG_RESET});
        chk(3'h5, 32'h0);
        `CHK("ctrl", ctrl, 8'h80)
        wr_reg(HREG_CFG, 32'h0);
        repeat (10) @(posedge mclk_i);
        `CHK("dreset", drst, 1'b1)
        wr_reg(HREG_CFG, 32'h2);
        repeat (10) @(posedge mclk_i);
        `CHK("syncs", sd_n, 1)
        for (int p = 0; p < 2; p++) begin
            wr_reg(HREG_CFG, 32'h2 | p);
            load;
            cmd(32'h30001);
            chk(HREG_RXDATA, {8'h0, w}, 32'hffffff);
            chk(HREG_STATUS, 32'h2);
        end
        load;
        cmd(32'h10010);
        chk(HREG_RXDATA, 32'h0, 32'hff);
        cmd(32'h40850);
        `CHK("ctrl", ctrl, 8'h08)
        cmd(32'h30001);
        chk(HREG_RXDATA, {8'h0, rv(w)}, 32'hffffff);
        wr_reg(HREG_CFG, 32'ha);
        wr_reg(HREG_CMD, {24'h0, CMD_CONT_READ});
        chk(HREG_STATUS, 32'h6);
        wr_reg(HREG_CFG, 32'h6);
        cmd({24'h0, CMD_CONT_READ});
        load;
        cmd(32'h2000f);
        chk(HREG_RXDATA, {8'h0, rv(w)}, 32'hffffff);
        chk(HREG_STATUS, 32'h2);
        cmd(32'h10010);
        chk(HREG_RXDATA, 32'h11, 32'hff);
        wr_reg(HREG_CFG, 32'h2);
        cmd({24'h0, CMD_SYNC});
        `CHK("filter reset", fr_n, 1)
        `CHK("hold", mhold, 1'b1)
        cmd(32'h10010);
        `CHK("syncs", sd_n, 2)
        `CHK("hold", mhold, 1'b0)
        cmd({24'h0, CMD_RESET});
        `CHK("ctrl", ctrl, 8'h80)
        `CHK("soft resets", sr_n, 1)
        wr_reg(HREG_CFG, 32'h6);
        repeat (3) load;
        cmd(32'h30001);
        chk(HREG_RXDATA, {8'h0, w}, 32'hffffff);
        test_done;
    end
endmodule : adc_serial_slave_port_bench
`default_nettype wire
